// ---- core/pic_defs.svh ----
// Behaviour
// - enable register at 0x20, reset clears all
// - enable bits: 7 wake,6 pins,4 ep1,3 ep0,2,1 ticks
// - each source latches pending until serviced
// - request only while enable bit set
// - sample at instruction's last cycle, highest wins
// - service clears enables, then latch, then calls
// - call pushes pc with carry and zero
// - vectors two bytes apart, priority falls upward
// - latency: remaining cycles plus ten plus five
// - returns restore pc flags; irq return re-enables
// - pin edges, pull-up bit picks polarity
// - write-only pin enables at 0x04, 0x05
// - matched pins ored, or rise clocks group flop
// - group acknowledge clears flop and group enable
// - no new group event until or falls
// - enable toggle on held pin retriggers
// - no pin priority, pin enables kept
// - ep0 event on data written or ack
// - ep1 event only on transmit ack
// - nesting allowed by rewriting enable register
// - ticks masked by bits 1 and 2
// - wake latched on rising wake pin, bit 7
// - write-only pull-ups at 0x08, 0x09, reset clear
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_ADDR_PORT0_PIN_IRQ_ENABLES 8'h04
`define PIC_ADDR_PORT1_PIN_IRQ_ENABLES 8'h05
`define PIC_ADDR_P0_PULL 8'h08
`define PIC_ADDR_P1_PULL 8'h09
`define PIC_ADDR_GIE 8'h20
`define PIC_RST_REG 8'h00
`define PIC_GIE_RW_MASK 8'hde
`define PIC_BIT_FAST 1
`define PIC_BIT_MS 2
`define PIC_BIT_EP0 3
`define PIC_BIT_EP1 4
`define PIC_BIT_PINS 6
`define PIC_BIT_WAKE 7
`define PIC_VEC_STEP 8'h02
`define PIC_CALL_CYCLES 4'd10
`define PIC_JMP_CYCLES 4'd5
`endif

// ---- core/pic_pkg.sv ----
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b01,
    PIC_WAIT = 2'b10
  } pic_state_t;
endpackage : pic_pkg

// ---- core/pic_pin_group.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pic_defs.svh"
module pic_pin_group (
  input wire logic clock, // core clock
  input wire logic reset, // async, active high
  input wire logic [15:0] pins, // port pins, {port1, port0}
  input wire logic [15:0] pull, // pull-up bits = polarity
  input wire logic [15:0] pin_en, // per-pin enables
  output logic group_or // or of matched enabled pins
);
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
  } pic_pg_t;
  pic_pg_t q, d;
  logic [15:0] hit;

  // per pin: polarity-matched level, gated by enable
  for (genvar i = 0; i < 16; i++) begin : g_pin
    assign hit[i] = pin_en[i] & (pull[i] ? q.s2[i] : ~q.s2[i]);
  end

  // two-flop sync per pin; nothing reads the first stage but the second
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
  end

  // shared or; its rising edge is taken in the controller, so an enable toggle
  // on a held pin makes a fresh edge
  assign group_or = |hit;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : pic_pin_group
`default_nettype wire

// ---- core/pic_controller.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pic_defs.svh"
module pic_controller (
  input wire logic clock, // 12 MHz core clock
  input wire logic reset, // async, active high
  input wire logic io_write, // io write strobe from core
  input wire logic [7:0] io_addr, // io address
  input wire logic [7:0] io_wdata, // io write data
  input wire logic io_read, // io read strobe from core
  output logic [7:0] io_rdata, // read data, registered
  input wire logic irq_return_restore, // irq return executed
  input wire logic instr_last, // last cycle of instruction
  input wire logic fast_tick, // fast tick pulse
  input wire logic ms_tick, // millisecond tick pulse
  input wire logic ep0_event, // ep0 data in or tx acked
  input wire logic ep1_event, // ep1 tx acked
  input wire logic wake_pin, // wake pin, asynchronous
  input wire logic [7:0] port0_pins, // port 0 pins, async
  input wire logic [7:0] port1_pins, // port 1 pins, async
  output logic irq_req, // call request, held until ack
  output logic [7:0] irq_vector, // vector address
  input wire logic irq_ack, // core acknowledge pulse
  output logic [7:0] pending // raw pending latches
);
  typedef struct packed {
    pic_pkg::pic_state_t st;
    logic [7:0] gie;
    logic [7:0] port0_pin_irq_enables;
    logic [7:0] port1_pin_irq_enables;
    logic [7:0] p0_pull;
    logic [7:0] p1_pull;
    logic [7:0] pend;
    logic [2:0] sel;
    logic [7:0] vec;
    logic [7:0] saved_gie;
    logic [7:0] rdata;
    logic wk1;
    logic wk2;
    logic wk3;
    logic or_prev;
  } pic_st_t;
  pic_st_t q, d;
  logic group_or;
  logic [7:0] active;
  logic [7:0] ev;
  logic found;
  logic [2:0] best;

  pic_pin_group u_pins (
    .clock(clock),
    .reset(reset),
    .pins({port1_pins, port0_pins}),
    .pull({q.p1_pull, q.p0_pull}),
    .pin_en({q.port1_pin_irq_enables, q.port0_pin_irq_enables}),
    .group_or(group_or)
  );

  // events gathered per enable bit; bits 5 and 0 never set
  always_comb begin
    ev = 8'h00;
    ev[`PIC_BIT_FAST] = fast_tick;
    ev[`PIC_BIT_MS] = ms_tick;
    ev[`PIC_BIT_EP0] = ep0_event;
    ev[`PIC_BIT_EP1] = ep1_event;
    ev[`PIC_BIT_PINS] = group_or & ~q.or_prev;
    ev[`PIC_BIT_WAKE] = q.wk2 & ~q.wk3;
  end

  // masked requests; lowest bit number is highest priority
  assign active = q.pend & q.gie;
  always_comb begin
    found = 1'b0;
    best = 3'd0;
    for (int i = 7; i >= 1; i--) begin
      if (active[i]) begin
        found = 1'b1;
        best = 3'(i);
      end
    end
  end

  always_comb begin
    d = q;
    d.wk1 = wake_pin;
    d.wk2 = q.wk1;
    d.wk3 = q.wk2;
    d.or_prev = group_or;
    d.rdata = 8'h00;
    // register writes; pin registers are write-only
    if (io_write) begin
      case (io_addr)
        `PIC_ADDR_PORT0_PIN_IRQ_ENABLES: d.port0_pin_irq_enables = io_wdata;
        `PIC_ADDR_PORT1_PIN_IRQ_ENABLES: d.port1_pin_irq_enables = io_wdata;
        `PIC_ADDR_P0_PULL: d.p0_pull = io_wdata;
        `PIC_ADDR_P1_PULL: d.p1_pull = io_wdata;
        `PIC_ADDR_GIE: d.gie = io_wdata & `PIC_GIE_RW_MASK;
        default: d.gie = d.gie;
      endcase
    end
    if (io_read && io_addr == `PIC_ADDR_GIE) begin
      d.rdata = q.gie;
    end
    // the irq return puts back the enables cleared on entry
    if (irq_return_restore) begin
      d.gie = q.saved_gie;
    end
    case (q.st)
      pic_pkg::PIC_IDLE: begin
        // sampled only at the final cycle of an instruction
        if (instr_last && found) begin
          d.sel = best;
          d.vec = 8'(best) * `PIC_VEC_STEP;
          d.st = pic_pkg::PIC_WAIT;
        end
      end
      pic_pkg::PIC_WAIT: begin
        // core pushes pc, carry and zero then spends the call and
        // jump cycles; the ack comes with the push
        if (irq_ack) begin
          d.saved_gie = q.gie;
          // group enable stays off after return until code sets it
          if (q.sel == 3'(`PIC_BIT_PINS)) begin
            d.saved_gie[`PIC_BIT_PINS] = 1'b0;
          end
          d.gie = 8'h00;
          d.pend[q.sel] = 1'b0;
          d.st = pic_pkg::PIC_IDLE;
        end
      end
      default: d.st = pic_pkg::PIC_IDLE;
    endcase
    // new events win over the acknowledge clear
    d.pend = d.pend | ev;
  end

  assign irq_req = (q.st == pic_pkg::PIC_WAIT);
  assign irq_vector = q.vec;
  assign io_rdata = q.rdata;
  assign pending = q.pend;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= pic_pkg::PIC_IDLE;
      q.gie <= `PIC_RST_REG;
      q.port0_pin_irq_enables <= `PIC_RST_REG;
      q.port1_pin_irq_enables <= `PIC_RST_REG;
      q.p0_pull <= `PIC_RST_REG;
      q.p1_pull <= `PIC_RST_REG;
    end else begin
      q <= d;
    end
  end
endmodule : pic_controller
`default_nettype wire

// ---- tb/pic_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_core_model (
  input wire logic clock, // core clock
  input wire logic reset, // async reset
  input wire logic [3:0] ack_dly, // cycles before a call is taken
  input wire logic irq_req, // call request
  output logic instr_last, // last instruction cycle
  output logic irq_ack // call taken
);
  logic [3:0] ph_q, wt_q;
  // five-cycle instructions; a slow core lets the request stand
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ph_q <= 4'h0;
      wt_q <= 4'h0;
    end else begin
      ph_q <= instr_last ? 4'h0 : ph_q + 4'h1;
      wt_q <= (irq_req && !irq_ack) ? wt_q + 4'h1 : 4'h0;
    end
  end
  assign instr_last = (ph_q == 4'h4);
  assign irq_ack = irq_req && (wt_q >= ack_dly);
endmodule : pic_core_model
`default_nettype wire

// ---- tb/pic_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_monitor (
  input wire logic clock, // clock
  input wire logic reset, // reset
  input wire logic instr_last, // pick point
  input wire logic ep0_event, // ep0 pulse
  input wire logic ep1_event, // ep1 pulse
  input wire logic irq_req, // request
  input wire logic [7:0] irq_vector, // vector
  input wire logic irq_ack, // taken
  input wire logic [7:0] pending // latches
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // a request waits, then is taken
  sequence s_wait; irq_req && !irq_ack; endsequence
  sequence s_take; irq_req && irq_ack; endsequence
  property p_stand; s_wait |=> irq_req && $stable(irq_vector); endproperty
  a_stand: assert property (p_stand) else $error("req fell");
  property p_drop; s_take |=> !irq_req; endproperty
  a_drop: assert property (p_drop) else $error("req held");
  property p_vec; irq_req |-> irq_vector inside {2, 4, 6, 8, 12, 14}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_clr; s_take ##0 !(ep0_event || ep1_event)
    |=> !pending[$past(irq_vector) >> 1]; endproperty
  a_clr: assert property (p_clr) else $error("latch kept");
  property p_ep0; ep0_event |=> pending[3]; endproperty
  a_ep0: assert property (p_ep0) else $error("ep0 lost");
  property p_ep1; ep1_event |=> pending[4]; endproperty
  a_ep1: assert property (p_ep1) else $error("ep1 lost");
  property p_keep; pending[2] && !irq_ack |=> pending[2]; endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  property p_pick; $rose(irq_req) |-> $past(instr_last); endproperty
  a_pick: assert property (p_pick) else $error("early pick");
endmodule : pic_monitor
bind pic_controller pic_monitor u_mon (.clock(clock), .reset(reset),
  .instr_last(instr_last), .ep0_event(ep0_event), .ep1_event(ep1_event),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
  .pending(pending));
`default_nettype wire

// ---- tb/prioritized_interrupt_controller_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_controller_test;
  logic clock, reset, io_write, io_read, irq_return_restore, fast_tick;
  logic ms_tick, ep0_event, ep1_event, wake_pin, irq_req, irq_ack;
  logic instr_last;
  logic [7:0] io_addr, io_wdata, io_rdata, port0_pins, port1_pins;
  logic [7:0] irq_vector, pending;
  logic [3:0] ack_dly;
  int errors, checked;
  pic_controller uut (
    .clock(clock),
    .reset(reset),
    .io_write(io_write),
    .io_addr(io_addr),
    .io_wdata(io_wdata),
    .io_read(io_read),
    .io_rdata(io_rdata),
    .irq_return_restore(irq_return_restore),
    .instr_last(instr_last),
    .fast_tick(fast_tick),
    .ms_tick(ms_tick),
    .ep0_event(ep0_event),
    .ep1_event(ep1_event),
    .wake_pin(wake_pin),
    .port0_pins(port0_pins),
    .port1_pins(port1_pins),
    .irq_req(irq_req),
    .irq_vector(irq_vector),
    .irq_ack(irq_ack),
    .pending(pending)
  );
  pic_core_model core (
    .clock(clock),
    .reset(reset),
    .ack_dly(ack_dly),
    .irq_req(irq_req),
    .instr_last(instr_last),
    .irq_ack(irq_ack)
  );
  // 8 ns clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // strobes start a cycle late so back-to-back calls never retoggle
  task automatic wr(input logic [7:0] a, d);
    step(1);
    io_addr = a;
    io_wdata = d;
    io_write = 1'b1;
    step(1);
    io_write = 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, e);
    step(1);
    io_addr = a;
    io_read = 1'b1;
    step(1);
    io_read = 1'b0;
    chk("rdata", io_rdata, e);
  endtask : rchk
  // bounded wait on the request level
  task automatic wt(input logic l);
    int i;
    for (i = 0; i < 60 && irq_req !== l; i++) step(1);
    if (i == 60) begin
      errors++;
      print_verdict();
    end
  endtask : wt
  task automatic svc(input logic [7:0] v);
    wt(1'b1);
    chk("vector", irq_vector, v);
    wt(1'b0);
  endtask : svc
  // reset, then masking, priority, pin group and wake
  initial begin
    {io_write, io_read, irq_return_restore, fast_tick, ms_tick} = '0;
    {ep0_event, ep1_event, wake_pin, io_addr, io_wdata} = '0;
    {port0_pins, port1_pins} = '0;
    ack_dly = 4'h2;
    errors = 0;
    checked = 0;
    reset = 1'b1;
    step(10);
    reset = 1'b0;
    rchk(8'h20, 8'h00);
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'hde);
    rchk(8'h04, 8'h00);
    wr(8'h20, 8'h00);
    {fast_tick, ms_tick, ep1_event} = 3'b111;
    step(1);
    {fast_tick, ms_tick, ep1_event} = 3'b000;
    step(8);
    chk("pending", pending, 8'h16);
    chk("irq_req", {7'h00, irq_req}, 8'h00);
    wr(8'h20, 8'h16);
    svc(8'h02);
    rchk(8'h20, 8'h00);
    chk("pending", pending, 8'h14);
    irq_return_restore = 1'b1;
    step(1);
    irq_return_restore = 1'b0;
    svc(8'h04);
    ack_dly = 4'h0;
    wr(8'h08, 8'h03);
    wr(8'h04, 8'h03);
    port0_pins = 8'h01;
    step(6);
    chk("pending", pending, 8'h50);
    port0_pins = 8'h03;
    wr(8'h20, 8'h40);
    svc(8'h0c);
    irq_return_restore = 1'b1;
    step(1);
    irq_return_restore = 1'b0;
    rchk(8'h20, 8'h00);
    step(6);
    chk("pending", pending, 8'h10);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h03);
    step(6);
    chk("pending", pending, 8'h50);
    wake_pin = 1'b1;
    ep0_event = 1'b1;
    step(1);
    ep0_event = 1'b0;
    step(6);
    chk("pending", pending, 8'hd8);
    print_verdict();
  end
endmodule : prioritized_interrupt_controller_test
`default_nettype wire
